// *** src/link_cfg_bank.sv ***
// Purpose: Link control two, reserved gen-two words and power management header
// Assumes: APB slave with zero wait states; straps stable around reset release
// Notes: Index addressing; byte address is four times the register index
//
// The APB interface to the registers was decided locally.

`timescale 1ns/1ps
`default_nettype none

module link_cfg_bank #(
    parameter int unsigned ADDR_W = 12,
    parameter logic [3:0] MAX_SUPPORTED = cfg_bank_pkg::SPEED_GEN1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port straps and mode
    input wire logic downstream_port,
    input wire logic compat_mode,
    input wire logic cfg_unlock,
    // Link events
    input wire logic hot_reset,
    input wire logic auto_speed_req,
    input wire logic [3:0] auto_speed,
    input wire logic link_unreliable,
    // Link control results
    output logic [3:0] advertise_speed_max,
    output logic [3:0] link_speed,
    output logic auto_change_refused,
    output logic compliance_active,
    output logic [3:0] compliance_speed
);

    // Bus state
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    // Stored fields
    logic [3:0] target_link_speed_q;
    logic force_compliance_q;
    logic autonomous_speed_change_disable_q;
    logic [7:0] next_capability_link_q;
    logic downstream_q;
    logic defaults_loaded_q;

    // Compliance sequencing
    cfg_bank_pkg::compliance_state_t cmp_state_q;
    cfg_bank_pkg::compliance_state_t cmp_state_d;
    logic compliance_active_q;
    logic [3:0] compliance_speed_q;

    // Decode
    logic [cfg_bank_pkg::IDX_W-1:0] idx;
    logic mapped;
    logic setup_phase;
    logic write_commit;
    logic ctl_write;
    logic nxt_write;

    // Visible field values after the compatibility mask
    logic [3:0] speed_eff;
    logic fc_eff;
    logic ascd_eff;

    // Read words
    logic [31:0] ctl_word;
    logic [31:0] pm_word;
    logic [31:0] rd_word;

    assign idx = paddr[cfg_bank_pkg::IDX_W+1:2];
    assign setup_phase = psel && !penable;
    assign write_commit = psel && penable && pready_q && pwrite;

    // Which indices answer without error
    always_comb begin
        case (idx)
            cfg_bank_pkg::IDX_DEV_CAP2,
            cfg_bank_pkg::IDX_DEV_CTL2,
            cfg_bank_pkg::IDX_DEV_STS2,
            cfg_bank_pkg::IDX_LINK_CAP2,
            cfg_bank_pkg::IDX_LINK_CTL2,
            cfg_bank_pkg::IDX_LINK_STS2,
            cfg_bank_pkg::IDX_SLOT_CAP2,
            cfg_bank_pkg::IDX_SLOT_CTL2,
            cfg_bank_pkg::IDX_SLOT_STS2,
            cfg_bank_pkg::IDX_PM_CAP: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Compatibility mode hides the fields but keeps their storage untouched
    assign speed_eff = compat_mode ? cfg_bank_pkg::SPD_RST : target_link_speed_q;
    assign fc_eff = compat_mode ? 1'b0 : force_compliance_q;
    assign ascd_eff = compat_mode ? 1'b0 : autonomous_speed_change_disable_q;

    // Write strobes per writable lane; compatibility mode drops control writes
    assign ctl_write = write_commit && idx == cfg_bank_pkg::IDX_LINK_CTL2 &&
        pstrb[cfg_bank_pkg::LANE_CTL] && !compat_mode;
    assign nxt_write = write_commit && idx == cfg_bank_pkg::IDX_PM_CAP &&
        pstrb[cfg_bank_pkg::LANE_NXT] && cfg_unlock;

    // Link control two as read; upper bits stay zero
    always_comb begin
        ctl_word = cfg_bank_pkg::WORD_ZERO;
        ctl_word[cfg_bank_pkg::SPD_LSB +: cfg_bank_pkg::SPD_W] = speed_eff;
        ctl_word[cfg_bank_pkg::FC_BIT] = fc_eff;
        ctl_word[cfg_bank_pkg::ASCD_BIT] = ascd_eff;
    end

    // Power management header as read
    always_comb begin
        pm_word = cfg_bank_pkg::WORD_ZERO;
        pm_word[cfg_bank_pkg::CAP_ID_LSB +: 8] = cfg_bank_pkg::CAP_ID_VAL;
        pm_word[cfg_bank_pkg::NXT_LSB +: 8] = next_capability_link_q;
        pm_word[cfg_bank_pkg::REV_LSB +: 3] = cfg_bank_pkg::REV_VAL;
        pm_word[cfg_bank_pkg::WCLK_BIT] = cfg_bank_pkg::WCLK_VAL;
    end

    // Read mux; every other word, mapped or not, reads zero
    always_comb begin
        case (idx)
            cfg_bank_pkg::IDX_LINK_CTL2: begin
                rd_word = ctl_word;
            end
            cfg_bank_pkg::IDX_PM_CAP: begin
                rd_word = pm_word;
            end
            default: begin
                rd_word = cfg_bank_pkg::WORD_ZERO;
            end
        endcase
    end

    // Answer one cycle after setup; data and error are held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else if (setup_phase) begin
            pready_q <= 1'b1;
        end else begin
            pready_q <= 1'b0;
        end
    end

    // Read data sampled at setup so it is stable for the whole access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= cfg_bank_pkg::WORD_ZERO;
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            prdata_q <= pwrite ? cfg_bank_pkg::WORD_ZERO : rd_word;
            pslverr_q <= !mapped;
        end else if (!psel) begin
            prdata_q <= cfg_bank_pkg::WORD_ZERO;
            pslverr_q <= 1'b0;
        end
    end

    // Port kind is a strap caught on the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            defaults_loaded_q <= 1'b0;
            downstream_q <= 1'b0;
        end else if (!defaults_loaded_q) begin
            defaults_loaded_q <= 1'b1;
            downstream_q <= downstream_port;
        end
    end

    // Next link: strap default first, then lock-gated writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_capability_link_q <= cfg_bank_pkg::NXT_UP_VAL;
        end else if (!defaults_loaded_q) begin
            next_capability_link_q <= downstream_port ? cfg_bank_pkg::NXT_DOWN_VAL
                : cfg_bank_pkg::NXT_UP_VAL;
        end else if (nxt_write) begin
            next_capability_link_q <= pwdata[cfg_bank_pkg::NXT_LSB +: 8];
        end
    end

    // Target speed and autonomous disable; hot reset clears them, and wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_link_speed_q <= cfg_bank_pkg::SPD_RST;
            autonomous_speed_change_disable_q <= 1'b0;
        end else if (hot_reset) begin
            target_link_speed_q <= cfg_bank_pkg::SPD_RST;
            autonomous_speed_change_disable_q <= 1'b0;
        end else if (ctl_write) begin
            // Reserved codes are stored as written; their effect is undefined
            target_link_speed_q <= pwdata[cfg_bank_pkg::SPD_LSB +: cfg_bank_pkg::SPD_W];
            autonomous_speed_change_disable_q <= pwdata[cfg_bank_pkg::ASCD_BIT];
        end
    end

    // Force bit is sticky: only the bus reset or a write of zero clears it, hot reset does not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_compliance_q <= 1'b0;
        end else if (ctl_write) begin
            force_compliance_q <= pwdata[cfg_bank_pkg::FC_BIT];
        end
    end

    // Compliance entry needs the bit armed before the hot reset arrives
    always_comb begin
        cmp_state_d = cmp_state_q;
        case (cmp_state_q)
            cfg_bank_pkg::CMP_IDLE: begin
                if (fc_eff) begin
                    cmp_state_d = cfg_bank_pkg::CMP_ARMED;
                end
            end
            cfg_bank_pkg::CMP_ARMED: begin
                if (!fc_eff) begin
                    cmp_state_d = cfg_bank_pkg::CMP_IDLE;
                end else if (hot_reset) begin
                    cmp_state_d = cfg_bank_pkg::CMP_ACTIVE;
                end
            end
            cfg_bank_pkg::CMP_ACTIVE: begin
                // Leaving takes the same route as entering: clear, then hot reset
                if (hot_reset && !fc_eff) begin
                    cmp_state_d = cfg_bank_pkg::CMP_IDLE;
                end
            end
            default: begin
                cmp_state_d = cfg_bank_pkg::CMP_IDLE;
            end
        endcase
    end

    // Compliance state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_state_q <= cfg_bank_pkg::CMP_IDLE;
        end else begin
            cmp_state_q <= cmp_state_d;
        end
    end

    // Compliance outputs; the speed is latched at entry from the target field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compliance_active_q <= 1'b0;
            compliance_speed_q <= cfg_bank_pkg::SPEED_NONE;
        end else begin
            compliance_active_q <= cmp_state_d == cfg_bank_pkg::CMP_ACTIVE;
            if (cmp_state_q == cfg_bank_pkg::CMP_ARMED &&
                cmp_state_d == cfg_bank_pkg::CMP_ACTIVE) begin
                compliance_speed_q <= speed_eff;
            end else if (cmp_state_d != cfg_bank_pkg::CMP_ACTIVE) begin
                compliance_speed_q <= cfg_bank_pkg::SPEED_NONE;
            end
        end
    end

    // Training-side speed policy
    speed_governor #(
        .MAX_SUPPORTED(MAX_SUPPORTED)
    ) u_governor (
        .pclk(pclk),
        .presetn(presetn),
        .downstream(downstream_q),
        .target_speed(speed_eff),
        .auto_disable(ascd_eff),
        .auto_req(auto_speed_req),
        .auto_speed(auto_speed),
        .link_unreliable(link_unreliable),
        .advertise_max_q(advertise_speed_max),
        .link_speed_q(link_speed),
        .refused_q(auto_change_refused)
    );

    // Bus outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign compliance_active = compliance_active_q;
    assign compliance_speed = compliance_speed_q;

endmodule

`default_nettype wire

// *** pkg/cfg_bank_pkg.sv ***
// Purpose: Shared constants and types for the link and power management bank
// Assumes: Register indices are word indices; byte address is four times the index
// Notes: Speed codes follow the target speed field encoding

package cfg_bank_pkg;

    // Register word indices
    localparam int unsigned IDX_W = 10;
    localparam logic [9:0] IDX_DEV_CAP2 = 10'h064;
    localparam logic [9:0] IDX_DEV_CTL2 = 10'h068;
    localparam logic [9:0] IDX_DEV_STS2 = 10'h06A;
    localparam logic [9:0] IDX_LINK_CAP2 = 10'h06C;
    localparam logic [9:0] IDX_LINK_CTL2 = 10'h070;
    localparam logic [9:0] IDX_LINK_STS2 = 10'h072;
    localparam logic [9:0] IDX_SLOT_CAP2 = 10'h074;
    localparam logic [9:0] IDX_SLOT_CTL2 = 10'h078;
    localparam logic [9:0] IDX_SLOT_STS2 = 10'h07A;
    localparam logic [9:0] IDX_PM_CAP = 10'h0C0;

    // Link control two fields
    localparam int unsigned SPD_LSB = 0;
    localparam int unsigned SPD_W = 4;
    localparam int unsigned FC_BIT = 4;
    localparam int unsigned ASCD_BIT = 5;

    // Power management header fields
    localparam int unsigned CAP_ID_LSB = 0;
    localparam int unsigned NXT_LSB = 8;
    localparam int unsigned REV_LSB = 16;
    localparam int unsigned WCLK_BIT = 19;

    // Byte lanes that carry writable fields
    localparam int unsigned LANE_CTL = 0;
    localparam int unsigned LANE_NXT = 1;

    // Fixed and reset values
    localparam logic [7:0] CAP_ID_VAL = 8'h01;
    localparam logic [7:0] NXT_UP_VAL = 8'h00;
    localparam logic [7:0] NXT_DOWN_VAL = 8'hD0;
    localparam logic [2:0] REV_VAL = 3'h3;
    localparam logic WCLK_VAL = 1'b0;
    localparam logic [3:0] SPD_RST = 4'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Speed codes
    localparam logic [3:0] SPEED_NONE = 4'h0;
    localparam logic [3:0] SPEED_GEN1 = 4'h1;
    localparam logic [3:0] SPEED_GEN2 = 4'h2;

    // Forced compliance sequencing
    typedef enum logic [1:0] {
        CMP_IDLE,
        CMP_ARMED,
        CMP_ACTIVE
    } compliance_state_t;

endpackage

// *** src/speed_governor.sv ***
// Purpose: Link speed cap for training and gate on autonomous speed changes
// Assumes: Speed change requests come from the link training logic as pulses
// Notes: Code zero in the target field means no cap beyond what is supported

`timescale 1ns/1ps
`default_nettype none

module speed_governor #(
    parameter logic [3:0] MAX_SUPPORTED = cfg_bank_pkg::SPEED_GEN1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Configuration view
    input wire logic downstream,
    input wire logic [3:0] target_speed,
    input wire logic auto_disable,
    // Training requests
    input wire logic auto_req,
    input wire logic [3:0] auto_speed,
    input wire logic link_unreliable,
    // Results
    output logic [3:0] advertise_max_q,
    output logic [3:0] link_speed_q,
    output logic refused_q
);

    logic [3:0] cap_d;
    logic allowed;

    // Downstream cap comes from the target field; upstream only by silicon limit
    always_comb begin
        cap_d = MAX_SUPPORTED;
        if (downstream && target_speed != cfg_bank_pkg::SPEED_NONE &&
            target_speed < MAX_SUPPORTED) begin
            cap_d = target_speed;
        end
    end

    // A disabled change may still step down to rescue a flaky link
    assign allowed = auto_speed != cfg_bank_pkg::SPEED_NONE && auto_speed <= cap_d &&
        (!auto_disable || (link_unreliable && auto_speed < link_speed_q));

    // Advertised cap follows the field one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            advertise_max_q <= cfg_bank_pkg::SPEED_GEN1;
        end else begin
            advertise_max_q <= cap_d;
        end
    end

    // Operating speed and refusal pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_speed_q <= cfg_bank_pkg::SPEED_GEN1;
            refused_q <= 1'b0;
        end else begin
            refused_q <= auto_req && !allowed;
            if (auto_req && allowed) begin
                link_speed_q <= auto_speed;
            end
        end
    end

endmodule

`default_nettype wire

// *** dv/link_cfg_bank_properties.sv ***
// Purpose: Port-level checks for the link and power management bank
// Assumes: Zero wait state APB slave; index addressing, byte address is four times index
// Notes: Bound onto every link_cfg_bank instance

`timescale 1ns/1ps
`default_nettype none

module link_cfg_bank_properties #(
    parameter int unsigned ADDR_W = 12,
    parameter logic [3:0] MAX_SUPPORTED = 4'h1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Mode and link events
    input wire logic compat_mode,
    input wire logic hot_reset,
    input wire logic auto_speed_req,
    input wire logic [3:0] auto_speed,
    // Link control results
    input wire logic [3:0] advertise_speed_max,
    input wire logic [3:0] link_speed,
    input wire logic auto_change_refused,
    input wire logic compliance_active,
    input wire logic [3:0] compliance_speed
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Decode of the word being answered; reserved words kept apart from link control and header
    logic [9:0] idx;
    logic resv;
    logic rd_ack;
    assign idx = paddr[11:2];
    assign resv = idx inside {10'h064, 10'h068, 10'h06A, 10'h06C, 10'h072, 10'h074, 10'h078,
                              10'h07A};
    assign rd_ack = pready && !pwrite;

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready one cycle after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_error_unmapped: assert property (pready |->
        pslverr == !(resv || idx == 10'h070 || idx == 10'h0C0))
        else $error("slave error does not match address map");
    a_reserved_zero: assert property (rd_ack && resv |-> prdata == 32'h0000_0000)
        else $error("reserved word read nonzero");
    a_header_fixed: assert property (rd_ack && idx == 10'h0C0 |->
        prdata[7:0] == 8'h01 && prdata[31:16] == 16'h0003)
        else $error("header fixed fields wrong");
    a_compat_zero: assert property (rd_ack && idx == 10'h070 && compat_mode |->
        prdata == 32'h0000_0000)
        else $error("link control nonzero in compatibility mode");
    a_refuse_bad_speed: assert property (auto_speed_req &&
        (auto_speed > MAX_SUPPORTED || auto_speed == 4'h0) |=>
        auto_change_refused && $stable(link_speed))
        else $error("unsupported speed request not refused");
    a_speed_steady: assert property (!auto_speed_req && !hot_reset |=> $stable(link_speed))
        else $error("link speed changed with no request");
    a_cap_range: assert property (advertise_speed_max != 4'h0 &&
        advertise_speed_max <= MAX_SUPPORTED)
        else $error("advertised cap outside supported range");
    a_comp_idle_zero: assert property (!compliance_active |-> compliance_speed == 4'h0)
        else $error("compliance speed shown while idle");
endmodule

bind link_cfg_bank link_cfg_bank_properties #(.ADDR_W(ADDR_W), .MAX_SUPPORTED(MAX_SUPPORTED)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compat_mode(compat_mode), .hot_reset(hot_reset), .auto_speed_req(auto_speed_req),
    .auto_speed(auto_speed), .advertise_speed_max(advertise_speed_max),
    .link_speed(link_speed), .auto_change_refused(auto_change_refused),
    .compliance_active(compliance_active), .compliance_speed(compliance_speed));

`default_nettype wire

// *** dv/link_cfg_bank_tb.sv ***
// Purpose: Self-checking bench for the link and power management bank
// Assumes: Reads answered one cycle after setup; expectations queued by the driver
// Notes: Random write data from an xorshift generator seeded at 85284

`timescale 1ns/1ps
`default_nettype none

module link_cfg_bank_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, v;
    logic [3:0] pstrb = 4'h0, auto_speed = 4'h0, adv, spd, cspd;
    logic pready, pslverr, refused, cact;
    logic downstream_port = 1'b1, compat_mode = 1'b0, cfg_unlock = 1'b0, hot_reset = 1'b0;
    logic auto_speed_req = 1'b0, link_unreliable = 1'b0;
    logic [32:0] exp_q[$];
    logic [31:0] seed = 32'h0001_4D24;
    int n_errors = 0, checks_done = 0;
    localparam logic [9:0] CTL = cfg_bank_pkg::IDX_LINK_CTL2, PM = cfg_bank_pkg::IDX_PM_CAP;
    localparam logic [9:0] RESV [8] = '{10'h064, 10'h068, 10'h06A, 10'h06C, 10'h072, 10'h074,
                                        10'h078, 10'h07A};

    // Two speeds built in so the downstream cap is visible against the silicon limit
    link_cfg_bank #(.MAX_SUPPORTED(4'h2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .downstream_port(downstream_port),
        .compat_mode(compat_mode), .cfg_unlock(cfg_unlock), .hot_reset(hot_reset),
        .auto_speed_req(auto_speed_req), .auto_speed(auto_speed),
        .link_unreliable(link_unreliable), .advertise_speed_max(adv), .link_speed(spd),
        .auto_change_refused(refused), .compliance_active(cact), .compliance_speed(cspd));

    // Clock, 5 ns period
    always #2.5 pclk = ~pclk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // One APB transfer; request held until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        pstrb <= s;
        // Ready is only honoured in the access phase; release happens after that edge
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (penable && pready === 1'b1) break;
            penable <= 1'b1;
        end
        if (n == 20) begin
            n_errors++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] idx, input logic [32:0] exp);
        exp_q.push_back(exp);
        apb(1'b0, idx, 32'h0000_0000, 4'h0);
    endtask

    task automatic rst(input logic ds);
        downstream_port <= ds;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    // Pulse an input for one cycle and let its result land before looking
    task automatic pulse(input logic hot, input logic [3:0] s, input logic unrel);
        @(posedge pclk);
        hot_reset <= hot;
        auto_speed_req <= !hot;
        auto_speed <= s;
        link_unreliable <= unrel;
        @(posedge pclk);
        hot_reset <= 1'b0;
        auto_speed_req <= 1'b0;
        @(posedge pclk);
    endtask

    // Read monitor: oldest queued expectation against error flag and data
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        complete_run();
    end

    initial begin
        rst(1'b1);
        foreach (RESV[i]) begin
            apb(1'b1, RESV[i], rnd(), 4'hF);
            rd(RESV[i], 33'h0);
        end
        apb(1'b1, 10'h065, 32'hFFFF_FFFF, 4'hF);
        rd(10'h065, 33'h1_0000_0000);
        rd(PM, 33'h0_0003_D001);
        apb(1'b1, PM, 32'hFFFF_FFFF, 4'hF);
        rd(PM, 33'h0_0003_D001);
        cfg_unlock <= 1'b1;
        apb(1'b1, PM, 32'hFFFF_ABFF, 4'h2);
        apb(1'b1, PM, 32'h0000_5500, 4'h1);
        rd(PM, 33'h0_0003_AB01);
        repeat (4) begin
            v = rnd();
            apb(1'b1, CTL, v, 4'hF);
            rd(CTL, {27'h0, v[5:0]});
        end
        apb(1'b1, CTL, 32'h0000_0015, 4'hE);
        rd(CTL, {27'h0, v[5:0]});
        compat_mode <= 1'b1;
        rd(CTL, 33'h0);
        apb(1'b1, CTL, 32'h0000_0015, 4'hF);
        compat_mode <= 1'b0;
        rd(CTL, {27'h0, v[5:0]});
        apb(1'b1, CTL, 32'h0000_0001, 4'hF);
        repeat (2) @(posedge pclk);
        check(adv, 4'h1);
        pulse(1'b0, 4'h2, 1'b0);
        check({refused, spd}, 5'h11);
        pulse(1'b0, 4'h0, 1'b0);
        check({refused, spd}, 5'h11);
        pulse(1'b0, 4'h1, 1'b0);
        check({refused, spd}, 5'h01);
        apb(1'b1, CTL, 32'h0000_0021, 4'hF);
        pulse(1'b0, 4'h1, 1'b0);
        check({refused, spd}, 5'h11);
        pulse(1'b0, 4'h1, 1'b1);
        check({refused, spd}, 5'h11);
        apb(1'b1, CTL, 32'h0000_0031, 4'hF);
        check({cact, cspd}, 5'h00);
        pulse(1'b1, 4'h0, 1'b0);
        check({cact, cspd}, 5'h11);
        rd(CTL, 33'h0_0000_0010);
        apb(1'b1, CTL, 32'h0000_0000, 4'hF);
        pulse(1'b1, 4'h0, 1'b0);
        check({cact, cspd}, 5'h00);
        rst(1'b0);
        rd(PM, 33'h0_0003_0001);
        rd(CTL, 33'h0);
        // Upstream ignores the field for its cap; then step down under the disable
        apb(1'b1, CTL, 32'h0000_0001, 4'hF);
        repeat (2) @(posedge pclk);
        check(adv, 4'h2);
        pulse(1'b0, 4'h2, 1'b0);
        check({refused, spd}, 5'h02);
        apb(1'b1, CTL, 32'h0000_0020, 4'hF);
        pulse(1'b0, 4'h1, 1'b0);
        check({refused, spd}, 5'h12);
        pulse(1'b0, 4'h1, 1'b1);
        check({refused, spd}, 5'h01);
        complete_run();
    end
endmodule

`default_nettype wire
